// ### hw/msi_request_mask_pending.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1: command bit 10 set by the host blocks all legacy interrupt signalling.
// R2: msi enable lives at bit 16 of the dword at config offset 0x050.
// R3: the host writes message address and data, used in every message.
// R4: vectors in use follow the multiple-message-enable field.
// R5: an accepted unmasked request with msi on emits a memory write.
// R6: every request is acknowledged, with code 0 when the message was sent.
// R7: with msi off or absent the message is dropped and code 0x2 returned.
// R8: a request on a masked vector sets its pending bit and sends nothing.
// R9: a masked request is acknowledged with code 2'b01 and no message.
// R10: clearing a mask with its pending bit set sends it and clears pending.
// R11: mask bits are kept per function and vector, written by the host.
// R12: the per-function pending word reads 1 for each suppressed vector.
// R13: pending cleared before unmask means no message and pending reads 0.
// R14: the host sets up legacy off, msi, address, data, count and masks first.
// R15: the application holds request, function and vector until acknowledge.
module msi_request_mask_pending #(
  parameter int          num_funcs   = 4,
  parameter logic        cap_present = 1'b1,
  parameter logic [2:0]  mmc_cap     = 3'h5
) (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire logic                           cfg_wr,
  input  wire logic                           cfg_rd,
  input  wire logic [$clog2(num_funcs)-1:0]   cfg_func,
  input  wire logic [11:0]                    cfg_addr,
  input  wire logic [31:0]                    cfg_wdata,
  output logic [31:0]                         cfg_rdata,
  output logic                                cfg_rd_valid,
  input  wire logic                           app_msi_req,
  input  wire logic [$clog2(num_funcs)-1:0]   app_msi_func,
  input  wire logic [msi_pkg::vec_w-1:0]      app_msi_num,
  output logic                                app_msi_ack,
  output logic [1:0]                          app_msi_status,
  input  wire logic                           app_intx_req,
  output logic                                intx_out,
  output logic                                msi_tlp_valid,
  output logic [63:0]                         msi_tlp_addr,
  output logic [31:0]                         msi_tlp_data,
  output logic [$clog2(num_funcs)-1:0]        msi_tlp_func
);
  import msi_pkg::*;

  localparam int func_w = $clog2(num_funcs);

  logic [15:0]       pci_command;
  logic              msi_enable;
  logic [mme_w-1:0]  mme;
  logic [63:0]       msi_addr;
  logic [31:0]       msi_data;
  req_state_type     state;
  logic [31:0]       flush [num_funcs];
  logic              rd_pend;
  logic [11:0]       rd_addr;
  logic [31:0]       app_mask;
  logic [31:0]       cfg_mask;
  logic [31:0]       cfg_pend;
  logic              flush_valid;
  logic [func_w-1:0] flush_func;
  logic [31:0]       flush_bits;
  logic              any_flush;
  logic [func_w-1:0] pick_func;
  logic [vec_w-1:0]  pick_vec;
  logic              cfg_write_mask;
  logic              cfg_write_pend;
  logic              masked_req;
  logic              look_go;

  // =====================================================================
  // helpers
  function automatic logic [vec_w-1:0] lowest_one(input logic [31:0] w);
    logic [vec_w-1:0] r;
    r = '0;
    for (int i = vec_count - 1; i >= 0; i--) begin
      if (w[i])
        r = i[vec_w-1:0];
    end
    return r;
  endfunction : lowest_one

  function automatic logic [31:0] msg_data(input logic [31:0]      d,
                                           input logic [mme_w-1:0] m,
                                           input logic [vec_w-1:0] v);
    logic [31:0] keep;
    keep = ~word_zero << m;
    return (d & keep) | ({27'h0, v} & ~keep); // R4
  endfunction : msg_data

  function automatic logic vec_allowed(input logic [mme_w-1:0] m,
                                       input logic [vec_w-1:0] v);
    logic [31:0] lim;
    lim = 32'h1 << m;
    return {27'h0, v} < lim; // R4
  endfunction : vec_allowed

  // =====================================================================
  // vector store
  assign cfg_write_mask = cfg_wr && cfg_addr == msi_vector_mask_offset;
  assign cfg_write_pend = cfg_wr && cfg_addr == msi_vector_pending_offset;
  assign look_go        = state == st_look && !any_flush;
  assign masked_req     = look_go && cap_present && msi_enable
                          && vec_allowed(mme, app_msi_num)
                          && app_mask[app_msi_num];

  msi_vector_store #(
    .num_funcs (num_funcs),
    .func_w    (func_w)
  ) u_store (
    .clk           (clk),
    .rstn          (rstn),
    .app_func      (app_msi_func),
    .cfg_func      (cfg_func),
    .mask_wr       (cfg_write_mask),
    .mask_wdata    (cfg_wdata),
    .pend_set      (masked_req),
    .pend_set_func (app_msi_func),
    .pend_set_vec  (app_msi_num),
    .pend_clr      (cfg_write_pend),
    .pend_clr_bits (cfg_wdata),
    .app_mask      (app_mask),
    .cfg_mask      (cfg_mask),
    .cfg_pend      (cfg_pend),
    .flush_valid   (flush_valid),
    .flush_func    (flush_func),
    .flush_bits    (flush_bits)
  );

  // =====================================================================
  // configuration writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pci_command <= command_reset;
      msi_enable  <= 1'b0;
      mme         <= '0;
      msi_addr    <= '0;
      msi_data    <= word_zero;
    end else if (cfg_wr) begin
      if (cfg_addr == pci_command_offset) begin
        pci_command <= cfg_wdata[15:0]; // R1
      end else if (cap_present
                   && cfg_addr == msi_capability_control_offset) begin
        msi_enable <= cfg_wdata[msi_enable_bit]; // R2
        mme        <= cfg_wdata[mme_lsb +: mme_w]; // R4
      end else if (cfg_addr == msi_addr_low_offset) begin
        msi_addr[31:0] <= {cfg_wdata[31:2], addr_align_zero}; // R3
      end else if (cfg_addr == msi_addr_high_offset) begin
        msi_addr[63:32] <= cfg_wdata; // R3
      end else if (cfg_addr == msi_data_offset) begin
        msi_data <= cfg_wdata; // R3
      end
    end
  end

  // =====================================================================
  // configuration reads, answered two edges after the request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_pend      <= 1'b0;
      rd_addr      <= '0;
      cfg_rd_valid <= 1'b0;
      cfg_rdata    <= word_zero;
    end else begin
      rd_pend      <= cfg_rd;
      rd_addr      <= cfg_addr;
      cfg_rd_valid <= rd_pend;
      if (!rd_pend) begin
        cfg_rdata <= word_zero;
      end else if (rd_addr == pci_command_offset) begin
        cfg_rdata <= {16'h0, pci_command};
      end else if (cap_present
                   && rd_addr == msi_capability_control_offset) begin
        cfg_rdata <= {7'h0, 1'b1, 1'b1, mme, mmc_cap, msi_enable,
                      8'h00, msi_cap_id};
      end else if (rd_addr == msi_addr_low_offset) begin
        cfg_rdata <= msi_addr[31:0];
      end else if (rd_addr == msi_addr_high_offset) begin
        cfg_rdata <= msi_addr[63:32];
      end else if (rd_addr == msi_data_offset) begin
        cfg_rdata <= msi_data;
      end else if (rd_addr == msi_vector_mask_offset) begin
        cfg_rdata <= cfg_mask;
      end else if (rd_addr == msi_vector_pending_offset) begin
        cfg_rdata <= cfg_pend; // R12
      end else begin
        cfg_rdata <= word_zero;
      end
    end
  end

  // =====================================================================
  // legacy interrupt gate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      intx_out <= 1'b0;
    else
      intx_out <= app_intx_req && !pci_command[intx_disable_bit]; // R1
  end

  // =====================================================================
  // unmask flush bookkeeping
  always_comb begin
    any_flush = 1'b0;
    pick_func = '0;
    pick_vec  = '0;
    for (int f = num_funcs - 1; f >= 0; f--) begin
      if (flush[f] != word_zero) begin
        any_flush = 1'b1;
        pick_func = f[func_w-1:0];
        pick_vec  = lowest_one(flush[f]);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int f = 0; f < num_funcs; f++)
        flush[f] <= word_zero;
    end else begin
      for (int f = 0; f < num_funcs; f++) begin
        logic [31:0] w;
        w = flush[f];
        if (any_flush && pick_func == f[func_w-1:0])
          w[pick_vec] = 1'b0;
        if (flush_valid && flush_func == f[func_w-1:0])
          w = w | flush_bits; // R10 R13
        flush[f] <= w;
      end
    end
  end

  // =====================================================================
  // request sequencer and acknowledge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state          <= st_idle;
      app_msi_ack    <= 1'b0;
      app_msi_status <= status_sent;
    end else begin
      app_msi_ack <= 1'b0;
      case (state)
        st_idle: begin
          if (app_msi_req)
            state <= st_look; // R15
        end
        st_look: begin
          if (!any_flush) begin
            state       <= st_done;
            app_msi_ack <= 1'b1; // R6
            if (!cap_present || !msi_enable
                || !vec_allowed(mme, app_msi_num))
              app_msi_status <= status_dropped; // R7
            else if (app_mask[app_msi_num])
              app_msi_status <= status_masked; // R9
            else
              app_msi_status <= status_sent; // R6
          end
        end
        st_done: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // =====================================================================
  // memory write message output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msi_tlp_valid <= 1'b0;
      msi_tlp_addr  <= '0;
      msi_tlp_data  <= word_zero;
      msi_tlp_func  <= '0;
    end else begin
      msi_tlp_valid <= 1'b0;
      if (any_flush) begin
        msi_tlp_valid <= cap_present && msi_enable; // R10
        msi_tlp_addr  <= msi_addr;
        msi_tlp_data  <= msg_data(msi_data, mme, pick_vec);
        msi_tlp_func  <= pick_func;
      end else if (look_go && cap_present && msi_enable
                   && vec_allowed(mme, app_msi_num)
                   && !app_mask[app_msi_num]) begin
        msi_tlp_valid <= 1'b1; // R5
        msi_tlp_addr  <= msi_addr; // R3
        msi_tlp_data  <= msg_data(msi_data, mme, app_msi_num);
        msi_tlp_func  <= app_msi_func;
      end
    end
  end
endmodule : msi_request_mask_pending
`default_nettype wire

// ### shared/msi_pkg.sv
package msi_pkg;
  // =====================================================================
  // configuration space offsets (byte addresses)
  localparam logic [11:0] pci_command_offset            = 12'h004;
  localparam logic [11:0] msi_capability_control_offset = 12'h050;
  localparam logic [11:0] msi_addr_low_offset           = 12'h054;
  localparam logic [11:0] msi_addr_high_offset          = 12'h058;
  localparam logic [11:0] msi_data_offset               = 12'h05C;
  localparam logic [11:0] msi_vector_mask_offset        = 12'h060;
  localparam logic [11:0] msi_vector_pending_offset     = 12'h064;
  // =====================================================================
  // field positions
  localparam int intx_disable_bit  = 10;
  localparam int msi_enable_bit    = 16;
  localparam int mmc_lsb           = 17;
  localparam int mme_lsb           = 20;
  localparam int addr64_bit        = 23;
  localparam int vec_mask_cap_bit  = 24;
  localparam int mme_w             = 3;
  localparam logic [7:0] msi_cap_id = 8'h05;
  localparam logic [1:0] addr_align_zero = 2'h0;
  localparam logic [15:0] command_reset = 16'h0000;
  localparam logic [31:0] word_zero     = 32'h0000_0000;
  // =====================================================================
  // vectors and result codes
  localparam int vec_count = 32;
  localparam int vec_w     = 5;
  localparam logic [1:0] status_sent    = 2'h0;
  localparam logic [1:0] status_masked  = 2'h1;
  localparam logic [1:0] status_dropped = 2'h2;
  // =====================================================================
  // request sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_look = 2'b01,
    st_done = 2'b10
  } req_state_type;
endpackage : msi_pkg

// ### hw/msi_vector_store.sv
`timescale 1ns/100ps
`default_nettype none
module msi_vector_store #(
  parameter int num_funcs = 4,
  parameter int func_w    = 2
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [func_w-1:0]    app_func,
  input  wire logic [func_w-1:0]    cfg_func,
  input  wire logic                 mask_wr,
  input  wire logic [31:0]          mask_wdata,
  input  wire logic                 pend_set,
  input  wire logic [func_w-1:0]    pend_set_func,
  input  wire logic [4:0]           pend_set_vec,
  input  wire logic                 pend_clr,
  input  wire logic [31:0]          pend_clr_bits,
  output logic [31:0]               app_mask,
  output logic [31:0]               cfg_mask,
  output logic [31:0]               cfg_pend,
  output logic                      flush_valid,
  output logic [func_w-1:0]         flush_func,
  output logic [31:0]               flush_bits
);
  import msi_pkg::*;

  logic [31:0] mask_mem [num_funcs];
  logic [31:0] pend_mem [num_funcs];

  // =====================================================================
  // mask and pending words
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int f = 0; f < num_funcs; f++) begin
        mask_mem[f] <= word_zero;
        pend_mem[f] <= word_zero;
      end
    end else begin
      for (int f = 0; f < num_funcs; f++) begin
        logic [31:0] p;
        p = pend_mem[f];
        if (pend_clr && cfg_func == f[func_w-1:0])
          p = p & ~pend_clr_bits; // R13
        if (mask_wr && cfg_func == f[func_w-1:0]) begin
          mask_mem[f] <= mask_wdata; // R11
          p = p & mask_wdata; // R10
        end
        if (pend_set && pend_set_func == f[func_w-1:0])
          p[pend_set_vec] = 1'b1; // R8
        pend_mem[f] <= p;
      end
    end
  end

  // =====================================================================
  // registered reads and unmask events
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      app_mask    <= word_zero;
      cfg_mask    <= word_zero;
      cfg_pend    <= word_zero;
      flush_valid <= 1'b0;
      flush_func  <= '0;
      flush_bits  <= word_zero;
    end else begin
      app_mask    <= mask_mem[app_func];
      cfg_mask    <= mask_mem[cfg_func];
      cfg_pend    <= pend_mem[cfg_func]; // R12
      flush_valid <= mask_wr;
      flush_func  <= cfg_func;
      flush_bits  <= pend_mem[cfg_func] & ~mask_wdata
                     & ((pend_clr) ? ~pend_clr_bits : ~word_zero); // R10
    end
  end
endmodule : msi_vector_store
`default_nettype wire

// ### testbench/msi_request_mask_pending_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module msi_request_mask_pending_monitor
  import msi_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rd_valid,
  input wire logic        app_msi_req,
  input wire logic        app_msi_ack,
  input wire logic [1:0]  app_msi_status,
  input wire logic        app_intx_req,
  input wire logic        intx_out,
  input wire logic        msi_tlp_valid,
  input wire logic [63:0] msi_tlp_addr,
  input wire logic [31:0] msi_tlp_data
);
  // =====================================================================
  // shadow of host settings
  logic        cmd_off;
  logic        en_q;
  logic [63:0] addr_q;
  logic [31:0] data_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_off <= 1'b0;
      en_q    <= 1'b0;
      addr_q  <= 64'h0;
      data_q  <= 32'h0;
    end else if (cfg_wr) begin
      if (cfg_addr == pci_command_offset)
        cmd_off <= cfg_wdata[intx_disable_bit];
      if (cfg_addr == msi_capability_control_offset)
        en_q <= cfg_wdata[msi_enable_bit];
      if (cfg_addr == msi_addr_low_offset)
        addr_q[31:0] <= cfg_wdata & 32'hFFFF_FFFC;
      if (cfg_addr == msi_addr_high_offset)
        addr_q[63:32] <= cfg_wdata;
      if (cfg_addr == msi_data_offset)
        data_q <= cfg_wdata;
    end
  end
  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_intx_gate: assert property (
    intx_out == $past(app_intx_req && !cmd_off))
    else $error("legacy level mismatch");
  a_msg_needs_en: assert property (
    msi_tlp_valid |-> $past(en_q)) else $error("message while disabled");
  a_msg_fields: assert property (
    msi_tlp_valid |-> msi_tlp_addr == $past(addr_q)
      && msi_tlp_data[31:5] == $past(data_q[31:5]))
    else $error("message fields wrong");
  a_sent_has_msg: assert property (
    app_msi_ack && app_msi_status == status_sent |-> msi_tlp_valid)
    else $error("sent code without message");
  a_ack_bound: assert property (
    $rose(app_msi_req) |-> ##[2:6] app_msi_ack) else $error("no ack");
  a_ack_pulse: assert property (
    app_msi_ack |=> !app_msi_ack) else $error("ack too long");
  a_off_drops: assert property (
    app_msi_ack && !$past(en_q) |-> app_msi_status == status_dropped)
    else $error("disabled request not dropped");
  a_masked_quiet: assert property (
    app_msi_ack && app_msi_status == status_masked |-> !msi_tlp_valid)
    else $error("masked request sent");
  a_rd_latency: assert property (
    cfg_rd |-> ##2 cfg_rd_valid) else $error("read answer late");
  a_rd_idle: assert property (
    !cfg_rd_valid |-> cfg_rdata == word_zero) else $error("stray rdata");
endmodule : msi_request_mask_pending_monitor
bind msi_request_mask_pending msi_request_mask_pending_monitor u_mon (
  .clk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
  .cfg_rd_valid, .app_msi_req, .app_msi_ack, .app_msi_status,
  .app_intx_req, .intx_out, .msi_tlp_valid, .msi_tlp_addr, .msi_tlp_data);
`default_nettype wire

// ### testbench/msi_app_model.sv
`timescale 1ns/100ps
`default_nettype none
module msi_app_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [1:0] func,
  input  wire logic [4:0] num,
  input  wire logic       app_msi_ack,
  input  wire logic [1:0] app_msi_status,
  output logic            app_msi_req,
  output logic [1:0]      app_msi_func,
  output logic [4:0]      app_msi_num,
  output logic [1:0]      last_status
);
  // =====================================================================
  // requester: hold until ack, then release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      app_msi_req  <= 1'b0;
      app_msi_func <= 2'h0;
      app_msi_num  <= 5'h0;
      last_status  <= 2'h3;
    end else if (start) begin
      app_msi_req  <= 1'b1;
      app_msi_func <= func;
      app_msi_num  <= num;
    end else if (app_msi_req && app_msi_ack) begin
      app_msi_req  <= 1'b0;
      app_msi_func <= ~app_msi_func;
      app_msi_num  <= ~app_msi_num;
      last_status  <= app_msi_status;
    end
  end
endmodule : msi_app_model
`default_nettype wire

// ### testbench/msi_request_mask_pending_tb.sv
`timescale 1ns/100ps
`default_nettype none
module msi_request_mask_pending_tb;
  import msi_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic        start = 1'b0, app_intx_req = 1'b0;
  logic [1:0]  cfg_func = 2'h0, func = 2'h0;
  logic [4:0]  num = 5'h0;
  logic [11:0] cfg_addr = 12'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, msi_tlp_data, tlp_d, d;
  logic [63:0] msi_tlp_addr, tlp_a;
  logic [1:0]  app_msi_func, app_msi_status, msi_tlp_func, last_status;
  logic [1:0]  tlp_f;
  logic [4:0]  app_msi_num;
  logic        cfg_rd_valid, app_msi_req, app_msi_ack, intx_out;
  logic        msi_tlp_valid;
  int          n_fail = 0, n_compared = 0, n_tlp = 0, n0, cyc = 0;
  msi_request_mask_pending u_dut (.clk, .rstn, .cfg_wr, .cfg_rd,
    .cfg_func, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rd_valid,
    .app_msi_req, .app_msi_func, .app_msi_num, .app_msi_ack,
    .app_msi_status, .app_intx_req, .intx_out, .msi_tlp_valid,
    .msi_tlp_addr, .msi_tlp_data, .msi_tlp_func);
  msi_app_model u_app (.clk, .rstn, .start, .func, .num, .app_msi_ack,
    .app_msi_status, .app_msi_req, .app_msi_func, .app_msi_num,
    .last_status);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (msi_tlp_valid === 1'b1) begin
      n_tlp++;
      tlp_a = msi_tlp_addr;
      tlp_d = msi_tlp_data;
      tlp_f = msi_tlp_func;
    end
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  // =====================================================================
  // shared tasks
  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [11:0] a, input logic [1:0] f, input logic [31:0] v);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_func <= f;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [1:0] f, output logic [31:0] v);
    v = 'x;
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    cfg_func <= f;
    @(posedge clk);
    cfg_rd <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (cfg_rd_valid === 1'b1) v = cfg_rdata;
    end
  endtask : rd
  task msi(input logic [1:0] f, input logic [4:0] v);
    int i;
    @(posedge clk);
    start <= 1'b1;
    func <= f;
    num <= v;
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (i = 0; i < 10 && app_msi_req === 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : msi
  task results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // =====================================================================
  // scenarios
  task t_reset_values;
    rd(pci_command_offset, 2'h0, d);
    check(d, 64'h0);
    rd(msi_capability_control_offset, 2'h0, d);
    check(d, 64'h018A_0005);
    rd(msi_vector_pending_offset, 2'h0, d);
    check(d, 64'h0);
    rd(12'h100, 2'h0, d);
    check(d, 64'h0);
    n0 = n_tlp;
    msi(2'h0, 5'h0);
    check(last_status, status_dropped);
    check(n_tlp, n0);
  endtask : t_reset_values
  task t_setup_send;
    @(posedge clk);
    app_intx_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(intx_out, 1'b1);
    wr(pci_command_offset, 2'h0, 32'h0000_0400);
    repeat (2) @(posedge clk);
    #1;
    check(intx_out, 1'b0);
    @(posedge clk);
    app_intx_req <= 1'b0;
    wr(msi_capability_control_offset, 2'h0, 32'h0021_0000);
    wr(msi_addr_low_offset, 2'h0, 32'h1234_5677);
    wr(msi_addr_high_offset, 2'h0, 32'hA5A5_0001);
    wr(msi_data_offset, 2'h0, 32'hBEEF_0000);
    rd(msi_capability_control_offset, 2'h0, d);
    check(d, 64'h01AB_0005);
    n0 = n_tlp;
    msi(2'h1, 5'h3);
    check(last_status, status_sent);
    check(n_tlp, n0 + 1);
    check(tlp_a, 64'hA5A5_0001_1234_5674);
    check(tlp_d, 64'hBEEF_0003);
    check(tlp_f, 2'h1);
    msi(2'h1, 5'h4);
    check(last_status, status_dropped);
  endtask : t_setup_send
  task t_mask_flush;
    wr(msi_vector_mask_offset, 2'h1, 32'h0000_0004);
    n0 = n_tlp;
    msi(2'h1, 5'h2);
    check(last_status, status_masked);
    check(n_tlp, n0);
    rd(msi_vector_pending_offset, 2'h1, d);
    check(d, 64'h4);
    rd(msi_vector_pending_offset, 2'h0, d);
    check(d, 64'h0);
    msi(2'h0, 5'h2);
    check(last_status, status_sent);
    n0 = n_tlp;
    wr(msi_vector_mask_offset, 2'h1, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    check(n_tlp, n0 + 1);
    check(tlp_d, 64'hBEEF_0002);
    rd(msi_vector_pending_offset, 2'h1, d);
    check(d, 64'h0);
  endtask : t_mask_flush
  task t_pend_drop;
    wr(msi_vector_mask_offset, 2'h1, 32'h0000_0004);
    msi(2'h1, 5'h2);
    check(last_status, status_masked);
    wr(msi_vector_pending_offset, 2'h1, 32'h0000_0004);
    n0 = n_tlp;
    wr(msi_vector_mask_offset, 2'h1, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    check(n_tlp, n0);
    rd(msi_vector_pending_offset, 2'h1, d);
    check(d, 64'h0);
  endtask : t_pend_drop
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values();
    t_setup_send();
    t_mask_flush();
    t_pend_drop();
    repeat (4) @(posedge clk);
    results();
  end
endmodule : msi_request_mask_pending_tb
`default_nettype wire
